// ==== core/fanaux_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fanaux_defines.vh"
module fanaux_regs (
  input  wire        clk_sys,          // System clock, 25 MHz
  input  wire        reset,            // Synchronous reset, active high
  input  wire [7:0]  reg_addr,         // Register address from serial bus engine
  input  wire [7:0]  reg_wdata,        // Write data
  input  wire        reg_wr,           // Write strobe, one cycle
  input  wire        reg_rd,           // Read strobe, one cycle
  output reg  [7:0]  reg_rdata,        // Read data, valid cycle after reg_rd
  input  wire        lock_bit,         // Global lock bit
  input  wire        start_bit,        // Global start bit
  input  wire        pwm_high_range,   // Drive outputs run in high frequency range
  input  wire [23:0] zone_temps,       // Zone temperatures, zone one low byte
  input  wire [23:0] zone_limits,      // Zone fan temperature limits
  input  wire [2:0]  spinup_active,    // Spin-up in progress per drive output
  input  wire [2:0]  spinup_time_done, // Configured spin-up time elapsed per drive
  input  wire [63:0] speed_counts,     // Raw speed counts, input one low word
  input  wire [3:0]  speed_below_min,  // Speed under minimum detectable per input
  output reg  [2:0]  zone_hold_min,    // Zone fan held at minimum duty
  output reg         xor_tree_enable,  // XOR-tree test mode active
  output reg  [1:0]  speed_input_one_mode,          // Effective mode, input one
  output reg  [1:0]  speed_input_two_mode,          // Effective mode, input two
  output reg  [1:0]  speed_inputs_three_four_mode,  // Effective mode, inputs three/four
  output reg  [3:0]  speed_comp_enable, // Drive compensation on per input
  output reg  [63:0] speed_results,     // Reported speed results
  output reg  [2:0]  spinup_end,        // Spin-up termination per drive output
  output reg         xor_tree_serial_excl // Serial bus pins held out of XOR tree
);
  reg  [7:0] hyst12_reg;
  reg  [7:0] hyst3_reg;
  reg  [7:0] test_reg;
  reg  [7:0] tachmode_reg;
  reg  [7:0] spinup_reg;
  reg  [7:0] rdata_next;
  wire [7:0] eff_hyst12;
  wire [7:0] eff_hyst3;
  wire [7:0] eff_test;
  wire [7:0] eff_tachmode;
  wire [7:0] eff_spinup;
  wire [2:0] hold_w;
  wire [1:0] mode_in [0:3];
  reg  [1:0] eff_mode [0:3];
  integer    i;
  integer    j;

  // Register writes; lockable registers frozen by lock, reserved bits dropped
  always @(posedge clk_sys) begin
    if (reset) begin
      hyst12_reg   <= `FANAUX_RST_HYST12;
      hyst3_reg    <= `FANAUX_RST_HYST3;
      test_reg     <= `FANAUX_RST_TEST;
      tachmode_reg <= `FANAUX_RST_TACHMODE;
      spinup_reg   <= `FANAUX_RST_SPINUP;
    end else if (reg_wr) begin
      case (reg_addr)
        `FANAUX_ADDR_HYST12: begin
          if (!lock_bit) begin
            hyst12_reg <= reg_wdata & `FANAUX_MASK_HYST12;
          end
        end
        `FANAUX_ADDR_HYST3: begin
          if (!lock_bit) begin
            hyst3_reg <= reg_wdata & `FANAUX_MASK_HYST3;
          end
        end
        `FANAUX_ADDR_TEST: begin
          if (!lock_bit) begin
            test_reg <= reg_wdata & `FANAUX_MASK_TEST;
          end
        end
        `FANAUX_ADDR_TACHMODE: begin
          tachmode_reg <= reg_wdata & `FANAUX_MASK_TACHMODE;
        end
        `FANAUX_ADDR_SPINUP: begin
          if (!lock_bit) begin
            spinup_reg <= reg_wdata & `FANAUX_MASK_SPINUP;
          end
        end
        default: begin
          hyst12_reg <= hyst12_reg;
        end
      endcase
    end
  end

  // Stored values are readable, but only take effect once start is set
  assign eff_hyst12   = start_bit ? hyst12_reg   : `FANAUX_RST_HYST12;
  assign eff_hyst3    = start_bit ? hyst3_reg    : `FANAUX_RST_HYST3;
  assign eff_test     = start_bit ? test_reg     : `FANAUX_RST_TEST;
  assign eff_tachmode = start_bit ? tachmode_reg : `FANAUX_RST_TACHMODE;
  assign eff_spinup   = start_bit ? spinup_reg   : `FANAUX_RST_SPINUP;

  always @* begin
    case (reg_addr)
      `FANAUX_ADDR_HYST12:   rdata_next = hyst12_reg;
      `FANAUX_ADDR_HYST3:    rdata_next = hyst3_reg & `FANAUX_MASK_HYST3;
      `FANAUX_ADDR_TEST:     rdata_next = test_reg & `FANAUX_MASK_TEST;
      `FANAUX_ADDR_TACHMODE: rdata_next = tachmode_reg & `FANAUX_MASK_TACHMODE;
      `FANAUX_ADDR_SPINUP:   rdata_next = spinup_reg & `FANAUX_MASK_SPINUP;
      default:               rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  fanaux_zone_hyst u_zone_one (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .zone_temp  (zone_temps[7:0]),
    .temp_limit (zone_limits[7:0]),
    .hyst       (eff_hyst12[7:4]),
    .hold_min   (hold_w[0])
  );
  fanaux_zone_hyst u_zone_two (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .zone_temp  (zone_temps[15:8]),
    .temp_limit (zone_limits[15:8]),
    .hyst       (eff_hyst12[3:0]),
    .hold_min   (hold_w[1])
  );
  fanaux_zone_hyst u_zone_three (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .zone_temp  (zone_temps[23:16]),
    .temp_limit (zone_limits[23:16]),
    .hyst       (eff_hyst3[7:4]),
    .hold_min   (hold_w[2])
  );

  // Inputs three and four share one field
  assign mode_in[0] = eff_tachmode[1:0];
  assign mode_in[1] = eff_tachmode[3:2];
  assign mode_in[2] = eff_tachmode[5:4];
  assign mode_in[3] = eff_tachmode[5:4];

  // High range forces mode 0 since compensation cannot track fast drive
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      eff_mode[i] = pwm_high_range ? 2'b00 : mode_in[i];
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      zone_hold_min                <= 3'b000;
      xor_tree_enable              <= 1'b0;
      xor_tree_serial_excl         <= 1'b1;
      speed_input_one_mode         <= 2'b00;
      speed_input_two_mode         <= 2'b00;
      speed_inputs_three_four_mode <= 2'b00;
      speed_comp_enable            <= 4'h0;
      speed_results                <= {4{`FANAUX_SPEED_SAT}};
      spinup_end                   <= 3'b000;
    end else begin
      zone_hold_min                <= hold_w;
      xor_tree_enable              <= eff_test[0];
      xor_tree_serial_excl         <= 1'b1;
      speed_input_one_mode         <= eff_mode[0];
      speed_input_two_mode         <= eff_mode[1];
      speed_inputs_three_four_mode <= eff_mode[2];
      // Compensation of input n follows drive n; inputs three/four follow drive three
      for (j = 0; j < 4; j = j + 1) begin
        speed_comp_enable[j] <= eff_mode[j][1];
        // Counts already scaled for two pulses per revolution upstream
        // Frequency-dependent floor is judged upstream and arrives as below_min
        if (eff_mode[j] != 2'b00 && speed_below_min[j]) begin
          speed_results[j*16 +: 16] <= `FANAUX_SPEED_SAT;
        end else begin
          speed_results[j*16 +: 16] <= speed_counts[j*16 +: 16];
        end
      end
      for (j = 0; j < 3; j = j + 1) begin
        if (eff_spinup[j]) begin
          spinup_end[j] <= spinup_active[j] &&
                           (spinup_time_done[j] || !speed_below_min[j]);
        end else begin
          spinup_end[j] <= spinup_active[j] && spinup_time_done[j];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/fanaux_defines.vh ====
// Summary of operation
// - After falling below limit, zone fan stays at minimum until limit minus hysteresis.
// - Zone one hysteresis bits 7:4, zone two 3:0 at 6Dh; zone three 7:4 at 6Eh.
// - Lock set makes hysteresis, test and spin-up registers read-only.
// - While start is clear, lockable registers act at defaults though writes are stored.
// - Test bit 0 enables XOR-tree test mode; writing 0 leaves it; default off.
// - Vendor range need not initialise except registers given defaults.
// - Speed mode register: input one 1:0, input two 3:2, inputs three/four 5:4.
// - All four speed modes in low frequency range; only mode 0 in high range.
// - Speed result assumes two pulses per fan revolution.
// - Modes 2 and 3 tie input one to drive one, two to two, three/four to three.
// - Mode 00 is plain pulse detection; result below minimum may be wrong.
// - Mode 01 is plain detection, reports all ones below minimum speed.
// - Modes 10 and 11 extend low range, all ones below minimum speed.
// - Minimum detectable speed depends on drive frequency and mode.
// - Speed mode register stays writable regardless of lock.
// - Spin-up bit clear: spin-up ends only when configured time elapses.
// - Spin-up bit set: ends at speed above minimum or time expiry, whichever first.
// - Reads of undefined addresses return zero.
// - Writes to undefined addresses are ignored without error.
// - Serial bus data and clock pins stay out of the XOR tree.
`ifndef FANAUX_DEFINES_VH
`define FANAUX_DEFINES_VH
`define FANAUX_ADDR_HYST12   8'h6D
`define FANAUX_ADDR_HYST3    8'h6E
`define FANAUX_ADDR_TEST     8'h6F
`define FANAUX_ADDR_TACHMODE 8'h74
`define FANAUX_ADDR_SPINUP   8'h75
`define FANAUX_RST_HYST12    8'h44
`define FANAUX_RST_HYST3     8'h40
`define FANAUX_RST_TEST      8'h00
`define FANAUX_RST_TACHMODE  8'h00
`define FANAUX_RST_SPINUP    8'h07
`define FANAUX_MASK_HYST12   8'hFF
`define FANAUX_MASK_HYST3    8'hF0
`define FANAUX_MASK_TEST     8'h01
`define FANAUX_MASK_TACHMODE 8'h3F
`define FANAUX_MASK_SPINUP   8'h07
`define FANAUX_SPEED_SAT     16'hFFFF
`define FANAUX_PULSES_PER_REV 2
`endif

// ==== core/fanaux_zone_hyst.v ====
`timescale 1ns/1ps
`default_nettype none
// One zone: holds fan at minimum between limit and limit minus hysteresis.
module fanaux_zone_hyst (
  input  wire       clk_sys,    // System clock
  input  wire       reset,      // Synchronous reset, active high
  input  wire [7:0] zone_temp,  // Signed zone temperature
  input  wire [7:0] temp_limit, // Signed fan temperature limit
  input  wire [3:0] hyst,       // Hysteresis in degrees
  output wire       hold_min    // Keep fan at minimum duty
);
  reg               was_above_reg;
  wire signed [9:0] t_s;
  wire signed [9:0] lim_s;
  wire signed [9:0] off_s;
  assign t_s   = {{2{zone_temp[7]}}, zone_temp};
  // Every compare must be signed, or a negative temperature would look hot
  assign lim_s = {{2{temp_limit[7]}}, temp_limit};
  // Widened so limit minus 15 never wraps
  assign off_s = lim_s - $signed({6'h00, hyst});
  always @(posedge clk_sys) begin
    if (reset) begin
      was_above_reg <= 1'b0;
    end else if (t_s > lim_s) begin
      was_above_reg <= 1'b1;
    end else if (t_s < off_s) begin
      was_above_reg <= 1'b0;
    end
  end
  assign hold_min = was_above_reg && (t_s >= off_s) && (t_s <= lim_s);
endmodule
`default_nettype wire

// ==== sim/fanaux_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module fanaux_chk (
  input wire logic        clk_sys,                      // Clock
  input wire logic        reset,                        // Sync reset
  input wire logic [7:0]  reg_addr,                     // Address
  input wire logic        reg_rd,                       // Read strobe
  input wire logic [7:0]  reg_rdata,                    // Read data
  input wire logic        start_bit,                    // Start
  input wire logic        pwm_high_range,               // High range
  input wire logic [63:0] speed_counts,                 // Raw counts
  input wire logic [3:0]  speed_below_min,              // Below minimum
  input wire logic [1:0]  speed_input_one_mode,         // Mode one
  input wire logic [1:0]  speed_input_two_mode,         // Mode two
  input wire logic [1:0]  speed_inputs_three_four_mode, // Mode three/four
  input wire logic [3:0]  speed_comp_enable,            // Compensation
  input wire logic [63:0] speed_results,                // Results
  input wire logic [2:0]  spinup_active,                // Spin-up busy
  input wire logic [2:0]  spinup_time_done,             // Time elapsed
  input wire logic [2:0]  spinup_end,                   // Spin-up end
  input wire logic        xor_tree_enable,              // Test mode
  input wire logic        xor_tree_serial_excl          // Bus pins out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire undef = !(reg_addr inside {8'h6D, 8'h6E, 8'h6F, 8'h74, 8'h75});
  sequence s_rd_undef;
    reg_rd && undef;
  endsequence
  // Outputs seen just after reset still carry reset values, so skip that edge
  sequence s_run;
    !$past(reset);
  endsequence
  AST_UNDEF_READ: assert property (s_rd_undef |=> reg_rdata == 8'h00)
    else $error("undefined read not zero");
  AST_RDATA_HOLD: assert property (s_run ##0 !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without read");
  AST_SERIAL_EXCL: assert property (s_run |-> xor_tree_serial_excl)
    else $error("bus pins in test tree");
  AST_HIGH_RANGE: assert property (s_run ##0 $past(pwm_high_range) |->
    speed_input_one_mode == 2'h0 && speed_inputs_three_four_mode == 2'h0)
    else $error("non-zero mode in high range");
  AST_COMP: assert property (speed_comp_enable == {speed_inputs_three_four_mode[1],
    speed_inputs_three_four_mode[1], speed_input_two_mode[1], speed_input_one_mode[1]})
    else $error("compensation pairing wrong");
  AST_RESULT: assert property (s_run |-> speed_results[15:0] ==
    ((speed_input_one_mode != 2'h0 && $past(speed_below_min[0])) ? 16'hFFFF
    : $past(speed_counts[15:0])))
    else $error("speed result wrong");
  AST_XOR_DEFAULT: assert property (s_run ##0 !$past(start_bit) |-> !xor_tree_enable)
    else $error("test mode without start");
  AST_MODE_DEFAULT: assert property (s_run ##0 !$past(start_bit) |->
    speed_input_two_mode == 2'h0)
    else $error("mode without start");
  AST_SPIN_TIME: assert property (s_run ##0 $past(spinup_time_done[0] && spinup_active[0])
    |-> spinup_end[0])
    else $error("spin-up outlived its time");
endmodule
bind fanaux_regs fanaux_chk i_fanaux_chk (.*);
`default_nettype wire

// ==== sim/fanaux_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module fanaux_host (
  input  wire logic       clk_sys,   // Clock
  output var  logic [7:0] reg_addr,  // Address
  output var  logic [7:0] reg_wdata, // Write data
  output var  logic       reg_wr,    // Write strobe
  output var  logic       reg_rd,    // Read strobe
  input  wire logic [7:0] reg_rdata  // Read data
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One byte per transfer; the edge between calls keeps strobes from double driving
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w,
                      output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk_sys);
    #1;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Idle lines show stale inverse, not the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, reset = 1'b1, lock_bit = 1'b0, start_bit = 1'b0, pwm_high_range = 1'b0;
  logic [23:0] zone_temps = 24'h00_0000, zone_limits = 24'h00_0032;
  logic [2:0] spinup_active = 3'h0, spinup_time_done = 3'h0, zone_hold_min, spinup_end;
  logic [63:0] speed_counts = 64'h0000_0000_0000_1234, speed_results;
  logic [3:0] speed_below_min = 4'h0, speed_comp_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic reg_wr, reg_rd, xor_tree_enable, xor_tree_serial_excl;
  logic [1:0] speed_input_one_mode, speed_input_two_mode, speed_inputs_three_four_mode;
  int error_cnt = 0;
  int check_count = 0;
  always #20 clk_sys = ~clk_sys;
  fanaux_regs i_fanaux_regs (.*);
  fanaux_host i_fanaux_host (.*);
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_fanaux_host.xfer(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [7:0] a);
    i_fanaux_host.xfer(a, 8'h00, 1'b0, q);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_regs;
    logic [7:0] a [5] = '{8'h6D, 8'h6E, 8'h6F, 8'h74, 8'h75};
    logic [7:0] rv [5] = '{8'h44, 8'h40, 8'h00, 8'h00, 8'h07};
    logic [7:0] mk [5] = '{8'hFF, 8'hF0, 8'h01, 8'h3F, 8'h07};
    logic [7:0] ua [4] = '{8'h00, 8'h70, 8'h76, 8'hFF};
    for (int i = 0; i < 5; i++) begin
      rd(a[i]);
      check("reset value", q, rv[i]);
      wr(a[i], 8'hFF);
      rd(a[i]);
      check("masked write", q, mk[i]);
      lock_bit = 1'b1;
      wr(a[i], 8'h00);
      rd(a[i]);
      check("locked write", q, (i == 3) ? 8'h00 : mk[i]);
      lock_bit = 1'b0;
      wr(a[i], rv[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ua[i], 8'hFF);
      rd(ua[i]);
      check("undefined read", q, 8'h00);
    end
    rd(8'h6D);
    check("after undefined writes", q, 8'h44);
  endtask
  task automatic t_start;
    wr(8'h6F, 8'h01);
    wait_n(2);
    check("test mode held off", xor_tree_enable, 1'b0);
    start_bit = 1'b1;
    wait_n(2);
    check("test mode on", xor_tree_enable, 1'b1);
    wr(8'h6F, 8'h00);
    wait_n(2);
    check("test mode off", xor_tree_enable, 1'b0);
  endtask
  task automatic t_speed;
    logic [1:0] m;
    speed_below_min = 4'hF;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(8'h74, {2'h0, m, ~m, m});
      wait_n(2);
      check("mode two", speed_input_two_mode, {~m});
      check("mode three four", speed_inputs_three_four_mode, m);
      check("speed two", speed_results[31:16], (m != 2'h3) ? 16'hFFFF : 16'h0000);
      check("speed four", speed_results[63:48], (m != 2'h0) ? 16'hFFFF : 16'h0000);
      check("comp", speed_comp_enable, {m[1], m[1], ~m[1], m[1]});
      check("speed one", speed_results[15:0], (m != 2'h0) ? 16'hFFFF : 16'h1234);
    end
    pwm_high_range = 1'b1;
    wait_n(2);
    check("high range", {speed_input_one_mode, speed_results[15:0]}, 18'h0_1234);
    pwm_high_range = 1'b0;
    speed_below_min = 4'h0;
  endtask
  task automatic t_spin;
    spinup_active = 3'h7;
    wr(8'h75, 8'h00);
    wait_n(2);
    check("no early end", spinup_end, 3'h0);
    wr(8'h75, 8'h05);
    wait_n(2);
    check("early end", spinup_end, 3'h5);
    spinup_time_done = 3'h7;
    wait_n(2);
    check("time end", spinup_end, 3'h7);
  endtask
  task automatic t_hyst;
    logic [7:0] t [4] = '{8'h33, 8'h30, 8'h2F, 8'h2E};
    logic [2:0] e [4] = '{3'h0, 3'h1, 3'h1, 3'h0};
    wr(8'h6D, 8'h30);
    for (int i = 0; i < 4; i++) begin
      zone_temps[7:0] = t[i];
      wait_n(4);
      check("hold minimum", zone_hold_min, e[i]);
    end
  endtask
  // Mid-run reset: stored values fall back to defaults, outputs to reset levels
  task automatic t_reset;
    wr(8'h6D, 8'h5A);
    reset = 1'b1;
    wait_n(1);
    check("reset spin end", spinup_end, 3'h0);
    check("reset bus pins out", xor_tree_serial_excl, 1'b1);
    reset = 1'b0;
    rd(8'h6D);
    check("reset default", q, 8'h44);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Whole run is near 141 cycles; the 2500-cycle limit allows about eighteen times that
  initial begin
    #100_000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_regs;
    t_start;
    t_speed;
    t_spin;
    t_hyst;
    t_reset;
    tally_and_finish;
  end
endmodule
`default_nettype wire
